/* File: stw_tx_format.sv */
// Overview of operation
// - Bits 7:4 give channel-status frequency code: 0 44.1k, 2 48k, 3 32k.
// - Frequency code changes only status bits, never the sample stream or its rate.
// - Bit 3 selects maximum word length: 0 gives 20 bits, 1 gives 24.
// - Bits 2:0 give valid bits; at 24 max, 5 means 24, 4 means 23.
// - Register resets to 0x002D; reserved bits 15:8 are written zero by software.
`timescale 1ns/100ps

module stw_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // Fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Drain side
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("stw_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    wr_ptr_nxt;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW-1:0]    rd_ptr_nxt;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             in_ready_r;
   logic             in_ready_nxt;
   logic             push;
   logic             pop;

   always_comb begin
      push       = in_valid_i && in_ready_r;
      pop        = out_ready_i && (count_r != '0);
      wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      count_nxt  = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // Ready is registered so the port comes straight from a flop
      in_ready_nxt = (count_nxt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         in_ready_r <= 1'b1;
      end else if (ce_i) begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
         in_ready_r <= in_ready_nxt;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (ce_i && push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   assign in_ready_o  = in_ready_r;
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
endmodule : stw_fifo

module stw_tx_format #(
   parameter int SAMPLE_W   = stw_pkg::STW_SAMPLE_W,
   parameter int FIFO_DEPTH = stw_pkg::STW_FIFO_DEPTH
) (
   // Clock, reset, enable
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // Register access
   input  wire logic [15:0]         reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic [15:0]         reg_wdata_i,
   input  wire logic                reg_rd_i,
   output logic      [15:0]         reg_rdata_o,
   // Sample input
   input  wire logic                smp_valid_i,
   input  wire logic [SAMPLE_W-1:0] smp_data_i,
   output logic                     smp_ready_o,
   // Sample output to the encoder
   output logic                     tx_valid_o,
   output logic      [SAMPLE_W-1:0] tx_sample_o,
   input  wire logic                tx_ready_i,
   // Channel-status fields
   output logic      [3:0]          cs_freq_o,
   output logic                     cs_wl_max_o,
   output logic      [2:0]          cs_wl_code_o,
   output logic      [4:0]          valid_bits_o
);
   import stw_pkg::*;

   initial begin
      if (SAMPLE_W != STW_SAMPLE_W)
         $error("stw_tx_format: SAMPLE_W must be 24");
   end

   logic [STW_STORED_W-1:0] ctrl_r;
   logic [STW_STORED_W-1:0] ctrl_nxt;
   logic [15:0]             rdata_r;
   logic [15:0]             rdata_nxt;
   logic [4:0]              vbits_r;
   logic [4:0]              vbits_nxt;
   logic                    reg_hit;

   // Valid bit count for a given field pair
   function automatic logic [4:0] stw_vbits(input logic wl_max, input logic [2:0] code);
      logic [4:0] top;
      top = wl_max ? STW_MAX_24 : STW_MAX_20;
      unique case (code)
         STW_WL_FULL:  stw_vbits = top;
         STW_WL_LESS1: stw_vbits = top - 5'h01;
         STW_WL_LESS2: stw_vbits = top - 5'h02;
         STW_WL_LESS3: stw_vbits = top - 5'h03;
         STW_WL_LESS4: stw_vbits = top - 5'h04;
         default:      stw_vbits = top;
      endcase
   endfunction : stw_vbits

   always_comb begin
      reg_hit   = (reg_addr_i == STW_FMT_CTRL_ADDR);
      ctrl_nxt  = ctrl_r;
      rdata_nxt = 16'h0000;
      if (reg_wr_i && reg_hit) begin
         ctrl_nxt = reg_wdata_i[STW_STORED_W-1:0];
      end
      if (reg_rd_i && reg_hit) begin
         rdata_nxt = {8'h00, ctrl_r};
      end
      vbits_nxt = stw_vbits(ctrl_nxt[STW_WLMAX_BIT], ctrl_nxt[STW_WLCODE_MSB:STW_WLCODE_LSB]);
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl_r  <= STW_FMT_CTRL_RST;
         rdata_r <= 16'h0000;
         vbits_r <= stw_vbits(STW_FMT_CTRL_RST[STW_WLMAX_BIT],
                              STW_FMT_CTRL_RST[STW_WLCODE_MSB:STW_WLCODE_LSB]);
      end else if (ce_i) begin
         ctrl_r  <= ctrl_nxt;
         rdata_r <= rdata_nxt;
         vbits_r <= vbits_nxt;
      end
   end

   assign cs_freq_o    = ctrl_r[STW_FREQ_MSB:STW_FREQ_LSB];
   assign cs_wl_max_o  = ctrl_r[STW_WLMAX_BIT];
   assign cs_wl_code_o = ctrl_r[STW_WLCODE_MSB:STW_WLCODE_LSB];
   assign valid_bits_o = vbits_r;
   assign reg_rdata_o  = rdata_r;

   // Sample path: FIFO then a masking output stage
   logic                fifo_valid;
   logic [SAMPLE_W-1:0] fifo_data;
   logic                take;
   logic                out_valid_r;
   logic                out_valid_nxt;
   logic [SAMPLE_W-1:0] out_data_r;
   logic [SAMPLE_W-1:0] out_data_nxt;
   logic [SAMPLE_W-1:0] keep_mask;

   stw_fifo #(
      .WIDTH (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .in_valid_i  (smp_valid_i),
      .in_data_i   (smp_data_i),
      .in_ready_o  (smp_ready_o),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_data),
      .out_ready_i (take)
   );

   always_comb begin
      take          = !out_valid_r || tx_ready_i;
      // frequency code plays no part here
      keep_mask     = ~(({SAMPLE_W{1'b1}}) >> vbits_r);
      out_valid_nxt = out_valid_r;
      out_data_nxt  = out_data_r;
      if (take) begin
         out_valid_nxt = fifo_valid;
         out_data_nxt  = fifo_data & keep_mask;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end else if (ce_i) begin
         out_valid_r <= out_valid_nxt;
         out_data_r  <= out_data_nxt;
      end
   end

   assign tx_valid_o  = out_valid_r;
   assign tx_sample_o = out_data_r;

   // Checks
   sequence ctrl_write_s;
      ce_i && reg_wr_i && reg_addr_i == STW_FMT_CTRL_ADDR;
   endsequence

   reset_value_a: assert property (@(posedge ref_clk_i)
      rst_i |=> (cs_freq_o == 4'h2 && cs_wl_max_o && cs_wl_code_o == 3'h5 && valid_bits_o == 5'h18))
      else $error("control register not at reset value");

   reserved_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      reg_rdata_o[15:8] == 8'h00)
      else $error("reserved bits read nonzero");

   freq_store_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ctrl_write_s |=> cs_freq_o == $past(reg_wdata_i[7:4]))
      else $error("frequency code not stored");

   freq_isolated_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ctrl_write_s ##0 (reg_wdata_i[3:0] == {cs_wl_max_o, cs_wl_code_o})
      |=> $stable(valid_bits_o) && ($past(take && ce_i) || $stable(tx_sample_o)))
      else $error("frequency write disturbed sample path");

   max20_limit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !cs_wl_max_o |-> valid_bits_o <= 5'h14 && valid_bits_o >= 5'h10)
      else $error("20-bit maximum exceeded");

   full24_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_wl_max_o && cs_wl_code_o == 3'h5 |-> valid_bits_o == 5'h18)
      else $error("code 5 at 24-bit maximum not 24 bits");

   less24_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_wl_max_o && cs_wl_code_o == 3'h4 |-> valid_bits_o == 5'h17)
      else $error("code 4 at 24-bit maximum not 23 bits");

   min20_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !cs_wl_max_o && cs_wl_code_o == 3'h1 |-> valid_bits_o == 5'h10)
      else $error("code 1 at 20-bit maximum not 16 bits");

   mask_apply_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ce_i && take && fifo_valid && vbits_r == 5'h14 |=> tx_sample_o[3:0] == 4'h0)
      else $error("invalid low bits not cleared");
endmodule : stw_tx_format

/* File: stw_pkg.sv */
package stw_pkg;
   // Register map
   localparam logic [15:0] STW_FMT_CTRL_ADDR  = 16'h008E;
   localparam logic [7:0]  STW_FMT_CTRL_RST   = 8'h2D;
   localparam int          STW_REG_W          = 16;
   localparam int          STW_STORED_W       = 8;
   // Field positions
   localparam int          STW_FREQ_MSB       = 7;
   localparam int          STW_FREQ_LSB       = 4;
   localparam int          STW_WLMAX_BIT      = 3;
   localparam int          STW_WLCODE_MSB     = 2;
   localparam int          STW_WLCODE_LSB     = 0;
   // Sampling-frequency status codes
   localparam logic [3:0]  STW_FREQ_44K1      = 4'h0;
   localparam logic [3:0]  STW_FREQ_48K       = 4'h2;
   localparam logic [3:0]  STW_FREQ_32K       = 4'h3;
   // Word-length codes and how many bits each drops below the maximum
   localparam logic [2:0]  STW_WL_FULL        = 3'h5;
   localparam logic [2:0]  STW_WL_LESS1       = 3'h4;
   localparam logic [2:0]  STW_WL_LESS2       = 3'h2;
   localparam logic [2:0]  STW_WL_LESS3       = 3'h6;
   localparam logic [2:0]  STW_WL_LESS4       = 3'h1;
   localparam logic [4:0]  STW_MAX_24         = 5'h18;
   localparam logic [4:0]  STW_MAX_20         = 5'h14;
   // Sample path
   localparam int          STW_SAMPLE_W       = 24;
   localparam int          STW_FIFO_DEPTH     = 16;
endpackage : stw_pkg

/* File: stw_rx_model.sv */
`timescale 1ns/100ps
module stw_rx_model (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Test control
   input  wire logic stall_i,
   // Link side
   output logic      tx_ready_o
);
   // Random back-pressure; a stall holds the link off entirely
   always_ff @(posedge ref_clk_i) begin
      if (rst_i)
         tx_ready_o <= 1'b0;
      else
         tx_ready_o <= !stall_i && ($urandom % 3 != 0);
   end
endmodule : stw_rx_model

/* File: stw_tx_format_tb.sv */
`timescale 1ns/100ps
module stw_tx_format_tb;
   import stw_pkg::*;
   logic        ref_clk_i, rst_i, ce_i, reg_wr_i, reg_rd_i, smp_valid_i, smp_ready_o;
   logic        tx_valid_o, tx_ready_i, cs_wl_max_o, stall, m;
   logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [23:0] smp_data_i, tx_sample_o, mask;
   logic [3:0]  cs_freq_o, f;
   logic [2:0]  cs_wl_code_o, c;
   logic [4:0]  valid_bits_o, vb;
   logic [23:0] exp_q[$];
   logic [3:0]  fq[3] = '{4'h0, 4'h2, 4'h3};
   logic [2:0]  cd[5] = '{3'h5, 3'h4, 3'h2, 3'h6, 3'h1};
   int          mismatches, checked, n;

   stw_tx_format stw_tx_format_i (.ref_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wr_i,
      .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .smp_valid_i, .smp_data_i, .smp_ready_o,
      .tx_valid_o, .tx_sample_o, .tx_ready_i, .cs_freq_o, .cs_wl_max_o, .cs_wl_code_o,
      .valid_bits_o);
   stw_rx_model stw_rx_model_i (.ref_clk_i, .rst_i, .stall_i(stall), .tx_ready_o(tx_ready_i));

   task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
      checked++;
      if (got !== ex) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic tally_and_finish;
      if (mismatches == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic chkf;
      chk("cs fields", 24'({f, m, c, vb}),
          24'({cs_freq_o, cs_wl_max_o, cs_wl_code_o, valid_bits_o}));
   endtask : chkf

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
      @(negedge ref_clk_i);
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_i = 1'b0;
      chk("reg_rdata_o", 24'(e), 24'(reg_rdata_o));
      @(negedge ref_clk_i);
   endtask : rd

   task automatic push(input logic [23:0] d);
      smp_valid_i = 1'b1;
      smp_data_i = d;
      while (smp_ready_o !== 1'b1) @(negedge ref_clk_i);
      exp_q.push_back(d & mask);
      @(negedge ref_clk_i);
   endtask : push

   // Outputs are settled at the falling edge; a word seen here is taken next rise
   always @(negedge ref_clk_i) begin
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
         chk("tx_sample_o", exp_q.size() ? exp_q.pop_front() : 24'hX, tx_sample_o);
   end

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(32'hAA1A348A));
      {rst_i, ce_i, reg_wr_i, reg_rd_i, smp_valid_i, stall} = 6'h30;
      {reg_addr_i, reg_wdata_i, smp_data_i} = '0;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      {f, m, c, vb} = {4'h2, 1'b1, 3'h5, 5'h18};
      chkf();
      rd(STW_FMT_CTRL_ADDR, 16'h002D);
      rd(16'h008F, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         f = fq[i % 3];
         m = (i < 5);
         c = cd[i % 5];
         vb = 5'((m ? 24 : 20) - i % 5);
         wr(STW_FMT_CTRL_ADDR, {8'h00, f, m, c});
         chkf();
         wr(16'h008F, 16'h0000);
         chkf();
         rd(STW_FMT_CTRL_ADDR, {8'h00, f, m, c});
         // Frequency alone changes; word length and samples must not
         f = fq[(i + 1) % 3];
         wr(STW_FMT_CTRL_ADDR, {8'h00, f, m, c});
         chkf();
         mask = 24'hFFFFFF << (24 - vb);
         repeat (4) push(24'($urandom));
         smp_valid_i = 1'b0;
         for (int k = 0; k < 200 && exp_q.size() != 0; k++) @(negedge ref_clk_i);
         repeat (2) @(negedge ref_clk_i);
      end
      // Enable low freezes the register: this write must not land
      ce_i = 1'b0;
      wr(STW_FMT_CTRL_ADDR, 16'h0031);
      chkf();
      ce_i = 1'b1;
      // Mid-run reset brings the defaults back
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      {f, m, c, vb} = {4'h2, 1'b1, 3'h5, 5'h18};
      chkf();
      rd(STW_FMT_CTRL_ADDR, 16'h002D);
      mask = 24'hFFFFFF;
      // Fill with the far side stalled: FIFO plus output stage before refusal
      stall = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      n = 0;
      smp_valid_i = 1'b1;
      while (smp_ready_o === 1'b1 && n < 40) begin
         smp_data_i = 24'($urandom);
         exp_q.push_back(smp_data_i & mask);
         n++;
         @(negedge ref_clk_i);
      end
      smp_valid_i = 1'b0;
      chk("accepted words", 24'(STW_FIFO_DEPTH + 1), 24'(n));
      stall = 1'b0;
      for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(negedge ref_clk_i);
      chk("words left", 24'h0, 24'(exp_q.size()));
      tally_and_finish();
   end
endmodule : stw_tx_format_tb
